/* File: verilog/ambient_light_dark_level_and_readout.sv */
`timescale 1ns/10ps
`default_nettype none
module ambient_light_dark_level_and_readout
	import light_pkg::*;
#(
	parameter int unsigned UPDATE_PERIOD = light_pkg::UPDATE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire light_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic dark_cmp_enable,
	input wire logic office_cmp_enable,
	input wire light_pkg::cmp_cfg_t office_cfg,
	input wire logic [light_pkg::COMP_W-1:0] dark_light_level,
	input wire logic [light_pkg::COMP_W-1:0] office_light_level,
	input wire logic sensor_one_enable,
	input wire logic sensor_two_enable,
	input wire logic [light_pkg::RESULT_W-1:0] sensor_one_code,
	input wire logic [light_pkg::RESULT_W-1:0] sensor_two_code,
	output light_pkg::backlight_mode_t backlight_mode
);
	// dark settings, mode and read answer state in one record; results and divider sit in submodules
	typedef struct packed {
		cmp_cfg_t dark_cfg; // host-written dark trip and margin
		backlight_mode_t mode; // current backlight level
		logic [7:0] rdata; // read answer byte
		logic rvalid; // read answer strobe
	} block_state_t;

	block_state_t state;
	block_state_t next_state;

	logic tick; // 80 ms refresh enable
	logic [RESULT_W-1:0] one_value; // first sensor result
	logic [RESULT_W-1:0] two_value; // second sensor result
	logic [COMP_W-1:0] dark_exit; // dark window top
	logic [COMP_W-1:0] office_exit; // office window top
	logic dark_below; // dark comparator trips low
	logic dark_above; // dark comparator trips high
	logic office_below; // office comparator trips low
	logic office_above; // office comparator trips high

	// refresh divider; parameter shortens it for simulation
	refresh_tick #(
		.PERIOD(UPDATE_PERIOD)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.tick(tick)
	);

	// first sensor conversion holding register
	sensor_result_hold u_one (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.enable(sensor_one_enable),
		.code(sensor_one_code),
		.value(one_value)
	);

	// second sensor conversion holding register
	sensor_result_hold u_two (
		.clk(clk),
		.rst(rst),
		.tick(tick),
		.enable(sensor_two_enable),
		.code(sensor_two_code),
		.value(two_value)
	);

	// comparator windows; margin codes share the fine 0.54 uA scale of the
	// dark level input, so the sum is a direct current comparison
	always_comb begin
		dark_exit = exit_level(state.dark_cfg);
		office_exit = exit_level(office_cfg);
		dark_below = dark_cmp_enable && (dark_light_level < {1'b0, state.dark_cfg.trip});
		dark_above = dark_cmp_enable && (dark_light_level > dark_exit);
		office_below = office_cmp_enable && (office_light_level < {1'b0, office_cfg.trip});
		office_above = office_cmp_enable && (office_light_level > office_exit);
	end

	// next state: register port, then mode selection
	always_comb begin
		next_state = state;
		next_state.rvalid = 1'b0;

		// writes: only the two dark settings are writable
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				ADDR_DARK_TRIP: begin
					next_state.dark_cfg.trip = reg_req.wdata;
				end
				ADDR_DARK_MARGIN: begin
					next_state.dark_cfg.margin = reg_req.wdata;
				end
				// result addresses and unmapped ones drop the write
				default: begin
					next_state.dark_cfg = state.dark_cfg;
				end
			endcase
		end

		// reads: answer byte registered, one cycle after the request
		if (reg_req.rd) begin
			next_state.rvalid = 1'b1;
			unique case (reg_req.addr)
				ADDR_DARK_TRIP: begin
					next_state.rdata = state.dark_cfg.trip;
				end
				ADDR_DARK_MARGIN: begin
					next_state.rdata = state.dark_cfg.margin;
				end
				ADDR_ONE_LOW: begin
					next_state.rdata = one_value[LOW_MSB:0];
				end
				ADDR_ONE_HIGH: begin
					next_state.rdata = high_byte(one_value);
				end
				ADDR_TWO_LOW: begin
					next_state.rdata = two_value[LOW_MSB:0];
				end
				ADDR_TWO_HIGH: begin
					next_state.rdata = high_byte(two_value);
				end
				// unmapped address reads as zero
				default: begin
					next_state.rdata = UNMAPPED_READ;
				end
			endcase
		end

		// mode selection; the dark comparator is looked at first so its
		// verdict overrides whatever the office comparator says
		if (dark_below) begin
			next_state.mode = MODE_DARK;
		end else if ((state.mode == MODE_DARK) && dark_above) begin
			next_state.mode = MODE_OFFICE;
		end else if ((state.mode == MODE_DARK) && dark_cmp_enable) begin
			// inside the dark window: hysteresis holds dark
			next_state.mode = MODE_DARK;
		end else if (office_below) begin
			next_state.mode = MODE_OFFICE;
		end else if ((state.mode == MODE_OFFICE) && office_above) begin
			next_state.mode = MODE_DAYLIGHT;
		end else begin
			// no trip: keep the present level
			next_state.mode = state.mode;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '{
				dark_cfg: '{trip: DARK_TRIP_RESET, margin: DARK_MARGIN_RESET},
				mode: MODE_DAYLIGHT,
				rdata: UNMAPPED_READ,
				rvalid: 1'b0
			};
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = state.rdata;
	assign reg_rvalid = state.rvalid;
	assign backlight_mode = state.mode;

	// read request at a given address
	sequence s_read_at(logic [7:0] a);
		reg_req.rd && (reg_req.addr == a);
	endsequence

	// dark comparator trips low
	sequence s_dark_low;
		dark_cmp_enable && (dark_light_level < {1'b0, state.dark_cfg.trip});
	endsequence

	// office comparator trips low
	sequence s_office_low;
		office_cmp_enable && (office_light_level < {1'b0, office_cfg.trip});
	endsequence

	// in dark and the level clears trip plus margin
	sequence s_dark_clear;
		(backlight_mode == MODE_DARK) && dark_cmp_enable &&
			(dark_light_level > ({1'b0, state.dark_cfg.trip} + {1'b0, state.dark_cfg.margin}));
	endsequence

	// with the dark comparator on, leaving dark needs the level above trip plus margin
	a_dark_exit: assert property (@(posedge clk) disable iff (rst)
		s_dark_clear |=> (backlight_mode == MODE_OFFICE))
		else $error("dark mode not left above trip plus margin");

	// full-scale margin code maps to the full current figure
	a_margin_scale: assert property (@(posedge clk) disable iff (rst)
		reg_req.wr && (reg_req.addr == ADDR_DARK_MARGIN) && (reg_req.wdata == 8'hFF)
			|=> (margin_na(state.dark_cfg.margin) == MARGIN_FULL_NA))
		else $error("full margin code does not map to full current");

	// low byte answers bits 7:0 of the first result
	a_one_low_read: assert property (@(posedge clk) disable iff (rst)
		s_read_at(ADDR_ONE_LOW) |=> reg_rvalid && (reg_rdata == $past(one_value[7:0])))
		else $error("first low byte read wrong");

	// high byte: reserved bits zero, result bits 12:8 below
	a_one_high_read: assert property (@(posedge clk) disable iff (rst)
		s_read_at(ADDR_ONE_HIGH) |=> reg_rvalid && (reg_rdata[7:5] == 3'h0) &&
			(reg_rdata[4:0] == $past(one_value[12:8])))
		else $error("first high byte read wrong");

	// back-to-back byte reads of the second result; no latching, so a
	// refresh between them may tear the pair
	a_two_bytes_read: assert property (@(posedge clk) disable iff (rst)
		s_read_at(ADDR_TWO_LOW) ##1 s_read_at(ADDR_TWO_HIGH)
			|-> (reg_rdata == $past(two_value[7:0])) ##1
			(reg_rdata == {3'h0, $past(two_value[12:8])}))
		else $error("second result bytes read wrong");

	// host writes to result addresses change nothing
	a_readonly_write: assert property (@(posedge clk) disable iff (rst)
		reg_req.wr && (reg_req.addr >= ADDR_ONE_LOW) && (reg_req.addr <= ADDR_TWO_HIGH) && !tick
			|=> $stable(one_value) && $stable(two_value) && $stable(state.dark_cfg))
		else $error("write to result register changed state");

	// below the dark trip the next mode is dark
	a_dark_entry: assert property (@(posedge clk) disable iff (rst)
		s_dark_low |=> (backlight_mode == MODE_DARK))
		else $error("dark mode not entered below dark trip");

	// both comparators low: dark beats office
	a_dark_priority: assert property (@(posedge clk) disable iff (rst)
		(s_dark_low and s_office_low) |=> (backlight_mode != MODE_OFFICE))
		else $error("office result overrode dark result");

	// office entry when the dark side is out of the way
	a_office_entry: assert property (@(posedge clk) disable iff (rst)
		s_office_low and (!dark_cmp_enable && (backlight_mode != MODE_DARK))
			|=> (backlight_mode == MODE_OFFICE))
		else $error("office mode not entered below office trip");

	// read strobe only follows a read request
	a_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
		!reg_req.rd |=> !reg_rvalid)
		else $error("read strobe without a read request");

	// in dark, dark enabled, level not above trip plus margin
	sequence s_dark_inside;
		(backlight_mode == MODE_DARK) && dark_cmp_enable &&
			!(dark_light_level > ({1'b0, state.dark_cfg.trip} + {1'b0, state.dark_cfg.margin}));
	endsequence

	// in office, dark side quiet, level above the office window
	sequence s_office_clear;
		(backlight_mode == MODE_OFFICE) && office_cmp_enable &&
			!(dark_cmp_enable && (dark_light_level < {1'b0, state.dark_cfg.trip})) &&
			(office_light_level > ({1'b0, office_cfg.trip} + {1'b0, office_cfg.margin}));
	endsequence

	// inside the band dark holds, so flicker near the trip cannot toggle modes
	a_dark_hold: assert property (@(posedge clk) disable iff (rst)
		s_dark_inside |=> (backlight_mode == MODE_DARK))
		else $error("dark mode left inside the hysteresis band");

	// office falls back to daylight only above its own trip plus margin
	a_office_exit: assert property (@(posedge clk) disable iff (rst)
		s_office_clear |=> (backlight_mode == MODE_DAYLIGHT))
		else $error("office mode not left above the office window");

	// a margin write sets the window top to trip plus exactly the code written
	a_margin_window: assert property (@(posedge clk) disable iff (rst)
		reg_req.wr && (reg_req.addr == ADDR_DARK_MARGIN)
			|=> (dark_exit ==
			({1'b0, state.dark_cfg.trip} + {1'b0, $past(reg_req.wdata)})))
		else $error("margin code not added to trip one for one");

	// a trip write lands in one cycle; the comparator uses it from then on
	a_trip_write: assert property (@(posedge clk) disable iff (rst)
		reg_req.wr && (reg_req.addr == ADDR_DARK_TRIP)
			|=> (state.dark_cfg.trip == $past(reg_req.wdata)))
		else $error("trip write did not land");

	// every read request is answered at the next edge
	a_read_answer: assert property (@(posedge clk) disable iff (rst)
		reg_req.rd |=> reg_rvalid)
		else $error("read request left unanswered");

	// the answer byte stands until the next read
	a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
		!reg_req.rd |=> $stable(reg_rdata))
		else $error("read answer changed without a read");

	// addresses outside the map read as the fixed unmapped byte
	a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
		reg_req.rd && ((reg_req.addr < ADDR_DARK_TRIP) || (reg_req.addr > ADDR_TWO_HIGH))
			|=> (reg_rdata == UNMAPPED_READ))
		else $error("unmapped read returned data");

	// the spare two-bit code of the mode is never reached
	a_mode_legal: assert property (@(posedge clk) disable iff (rst)
		backlight_mode inside {MODE_DAYLIGHT, MODE_OFFICE, MODE_DARK})
		else $error("backlight mode took an illegal code");
endmodule
`default_nettype wire

/* File: verilog/light_pkg.sv */
`default_nettype none
package light_pkg;
	// clock and refresh timing
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned UPDATE_PERIOD_MS = 80;
	localparam int unsigned CYCLES_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned UPDATE_CYCLES = UPDATE_PERIOD_MS * CYCLES_PER_MS;

	// register addresses on the host register port
	localparam logic [7:0] ADDR_DARK_TRIP = 8'h1F;
	localparam logic [7:0] ADDR_DARK_MARGIN = 8'h20;
	localparam logic [7:0] ADDR_ONE_LOW = 8'h21;
	localparam logic [7:0] ADDR_ONE_HIGH = 8'h22;
	localparam logic [7:0] ADDR_TWO_LOW = 8'h23;
	localparam logic [7:0] ADDR_TWO_HIGH = 8'h24;

	// reset values and the answer to an unmapped read
	localparam logic [7:0] DARK_TRIP_RESET = 8'h00;
	localparam logic [7:0] DARK_MARGIN_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [2:0] RESERVED_READ = 3'h0;

	// conversion result layout
	localparam int unsigned RESULT_W = 13;
	localparam int unsigned LOW_MSB = 7;
	localparam int unsigned HIGH_LSB = 8;
	localparam logic [12:0] RESULT_RESET = 13'h0000;

	// margin scale: code times step, in nA; all-ones code is the full figure
	localparam int unsigned MARGIN_STEP_NA = 540;
	localparam int unsigned MARGIN_FULL_NA = 137700;

	// comparator width: trip plus margin needs one extra bit
	localparam int unsigned COMP_W = 9;

	typedef enum logic [1:0] {
		MODE_DAYLIGHT,
		MODE_OFFICE,
		MODE_DARK
	} backlight_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [7:0] trip;
		logic [7:0] margin;
	} cmp_cfg_t;

	// upper edge of a comparator window, trip plus margin
	function automatic logic [COMP_W-1:0] exit_level(cmp_cfg_t cfg);
		exit_level = {1'b0, cfg.trip} + {1'b0, cfg.margin};
	endfunction

	// high byte of a result: reserved bits zero, result bits 12:8 below
	function automatic logic [7:0] high_byte(logic [RESULT_W-1:0] value);
		high_byte = {RESERVED_READ, value[RESULT_W-1:HIGH_LSB]};
	endfunction

	// margin code converted to photosensor current in nA
	function automatic int unsigned margin_na(logic [7:0] code);
		margin_na = int'(code) * MARGIN_STEP_NA;
	endfunction
endpackage
`default_nettype wire

/* File: verilog/refresh_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module refresh_tick #(
	parameter int unsigned PERIOD = 16000000
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);
	localparam int unsigned CNT_W = $clog2(PERIOD + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

	typedef struct packed {
		logic [CNT_W-1:0] count; // cycles since the last pulse
		logic tick; // one-cycle enable pulse
	} tick_state_t;

	tick_state_t state;
	tick_state_t next_state;

	// free-running divider, pulses once per period
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (state.count == LAST) begin
			next_state.count = '0;
			next_state.tick = 1'b1;
		end else begin
			next_state.count = state.count + CNT_W'(1);
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;

	a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
		tick |=> !tick)
		else $error("refresh pulse lasted more than one cycle");
endmodule
`default_nettype wire

/* File: verilog/sensor_result_hold.sv */
`timescale 1ns/10ps
`default_nettype none
module sensor_result_hold
	import light_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic enable,
	input wire logic [light_pkg::RESULT_W-1:0] code,
	output logic [light_pkg::RESULT_W-1:0] value
);
	typedef struct packed {
		logic [RESULT_W-1:0] value; // last captured conversion
	} hold_state_t;

	hold_state_t state;
	hold_state_t next_state;

	// capture on the refresh pulse only while the sensor is enabled
	always_comb begin
		next_state = state;
		if (tick && enable) begin
			next_state.value = code;
		end
	end

	// state register; host writes never reach it
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= '{value: RESULT_RESET};
		end else begin
			state <= next_state;
		end
	end

	assign value = state.value;

	a_refresh_capture: assert property (@(posedge clk) disable iff (rst)
		(tick && enable) |=> (value == $past(code)))
		else $error("result not refreshed on enabled pulse");

	a_result_hold: assert property (@(posedge clk) disable iff (rst)
		!(tick && enable) |=> $stable(value))
		else $error("result changed without an enabled refresh pulse");
endmodule
`default_nettype wire

/* File: tb/sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
// stands in for the two phototransistor converters
module sensor_model
	import light_pkg::*;
(
	input wire logic clk,
	input wire logic [light_pkg::RESULT_W-1:0] level_one,
	input wire logic [light_pkg::RESULT_W-1:0] level_two,
	output logic [light_pkg::RESULT_W-1:0] code_one,
	output logic [light_pkg::RESULT_W-1:0] code_two
);
	// codes move on the falling edge only, clear of the sampling edge;
	// one process drives them, so the codes are unknown until the first
	// falling edge, while the block still sits in reset
	always @(negedge clk) begin
		code_one <= level_one;
		code_two <= level_two;
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import light_pkg::*;
	localparam int unsigned PER = 8; // short refresh so the run stays brief
	logic clk, rst, rvalid, dcen, ocen, s1en, s2en;
	reg_req_t req; // host register request
	logic [7:0] rdata, trip, marg;
	cmp_cfg_t ocfg; // office settings held outside the block
	logic [COMP_W-1:0] dlev, olev;
	logic [RESULT_W-1:0] lv1, lv2, c1, c2, e2;
	backlight_mode_t mode;
	int n_fail, num_checks, seed, i;

	ambient_light_dark_level_and_readout #(.UPDATE_PERIOD(PER)) dut (.clk(clk), .rst(rst),
		.reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .dark_cmp_enable(dcen),
		.office_cmp_enable(ocen), .office_cfg(ocfg), .dark_light_level(dlev),
		.office_light_level(olev), .sensor_one_enable(s1en), .sensor_two_enable(s2en),
		.sensor_one_code(c1), .sensor_two_code(c2), .backlight_mode(mode));
	sensor_model sensors (.clk(clk), .level_one(lv1), .level_two(lv2), .code_one(c1),
		.code_two(c2));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run, also reached by a timed-out wait
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// byte compare
	task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// mode compare
	task chkm(input backlight_mode_t exp);
		num_checks++;
		if (mode !== exp) begin
			n_fail++;
			$display("CHECK FAILED backlight_mode expected %0d seen %0d", exp, mode);
		end
	endtask

	// expected high byte: top bits zero, result bits 12:8 below
	function automatic logic [7:0] hi_of(logic [12:0] v);
		return {3'h0, v[12:8]};
	endfunction

	// one-cycle write pulse, then one idle cycle so the next call starts
	// on a fresh falling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask

	// one-cycle read pulse, answer awaited under a bound
	task rd(input logic [7:0] a, output logic [7:0] d);
		int k;
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'b0;
		for (k = 0; k < 4 && rvalid !== 1'b1; k++) begin
			@(negedge clk);
		end
		if (rvalid !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED reg_rvalid expected 1 seen %b", rvalid);
			conclude();
		end
		d = rdata;
		@(negedge clk);
	endtask

	// read and compare one register
	task rdc(input string what, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk8(what, e, d);
	endtask

	// back-to-back reads of a low byte and the high byte above it;
	// each answer is taken at the falling edge where it stands
	task rd_pair(input logic [7:0] a, output logic [7:0] lo, output logic [7:0] hi);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge clk);
		lo = rdata;
		req.addr = a + 8'h01;
		@(negedge clk);
		hi = rdata;
		req.rd = 1'b0;
		@(negedge clk);
	endtask

	// all four result bytes against two expected results
	task res_chk(input logic [12:0] e1, input logic [12:0] ex2);
		logic [7:0] lo, hi;
		rdc("one_low", ADDR_ONE_LOW, e1[7:0]);
		rdc("one_high", ADDR_ONE_HIGH, hi_of(e1));
		rd_pair(ADDR_TWO_LOW, lo, hi);
		chk8("two_low", ex2[7:0], lo);
		chk8("two_high", hi_of(ex2), hi);
	endtask

	// set light levels, let the registered mode settle, compare
	task mode_at(input logic [8:0] d, input logic [8:0] o, input backlight_mode_t e);
		dlev = d;
		olev = o;
		repeat (2) @(negedge clk);
		chkm(e);
	endtask

	// main sequence
	initial begin
		seed = 32'h4F905C91;
		n_fail = 0;
		num_checks = 0;
		rst = 1'b1;
		req = '0;
		{dcen, ocen, s1en, s2en} = 4'h0;
		ocfg = '0;
		dlev = 9'h1FF;
		olev = 9'h1FF;
		lv1 = 13'h1ABC; // live codes present while sensors are off
		lv2 = 13'h0555;
		e2 = '0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		// reset values, disabled sensors never refresh, unmapped read
		rdc("trip_reset", ADDR_DARK_TRIP, 8'h00);
		rdc("margin_reset", ADDR_DARK_MARGIN, 8'h00);
		res_chk(13'h0000, 13'h0000);
		rdc("unmapped", 8'h25, 8'h00);
		// random settings round trip
		for (i = 0; i < 4; i++) begin
			trip = 8'($random(seed));
			marg = 8'($random(seed));
			wr(ADDR_DARK_TRIP, trip);
			wr(ADDR_DARK_MARGIN, marg);
			rdc("trip", ADDR_DARK_TRIP, trip);
			rdc("margin", ADDR_DARK_MARGIN, marg);
		end
		// refresh with fixed codes first, then random ones; last pass has sensor two off
		s1en = 1'b1;
		for (i = 0; i < 6; i++) begin
			lv1 = (i == 0) ? 13'h1FFF : 13'($random(seed));
			lv2 = (i == 0) ? 13'h1F00 : 13'($random(seed));
			s2en = (i != 5);
			repeat (PER + 3) @(negedge clk);
			if (s2en) begin
				e2 = lv2;
			end
			// host writes to read-only results must be lost
			wr(ADDR_ONE_LOW, ~lv1[7:0]);
			wr(ADDR_TWO_HIGH, 8'hFF);
			rdc("one_low_after_write", ADDR_ONE_LOW, lv1[7:0]);
			res_chk(lv1, e2);
		end
		// mode walk, all-ones margin on top of a small trip
		wr(ADDR_DARK_TRIP, 8'h10);
		wr(ADDR_DARK_MARGIN, 8'hFF);
		ocfg.trip = 8'h40;
		ocfg.margin = 8'h10;
		{dcen, ocen} = 2'b11;
		mode_at(9'h1FF, 9'h1FF, MODE_DAYLIGHT);
		mode_at(9'h1FF, 9'h03F, MODE_OFFICE);
		mode_at(9'h00F, 9'h03F, MODE_DARK);
		mode_at(9'h10F, 9'h03F, MODE_DARK);
		mode_at(9'h110, 9'h045, MODE_OFFICE);
		mode_at(9'h110, 9'h051, MODE_DAYLIGHT);
		mode_at(9'h00F, 9'h000, MODE_DARK);
		mode_at(9'h110, 9'h050, MODE_OFFICE);
		mode_at(9'h110, 9'h1FF, MODE_DAYLIGHT);
		dcen = 1'b0;
		mode_at(9'h000, 9'h03F, MODE_OFFICE);
		// mid-run reset with sensors off: everything back to reset values
		olev = 9'h1FF;
		s1en = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chkm(MODE_DAYLIGHT);
		rdc("trip_after_reset", ADDR_DARK_TRIP, 8'h00);
		rdc("margin_after_reset", ADDR_DARK_MARGIN, 8'h00);
		res_chk(13'h0000, 13'h0000);
		conclude();
	end
endmodule
`default_nettype wire
